// ===== hw/hbcp_cfg.svh
// Constants for the half-bridge command port
`ifndef HBCP_CFG_SVH
`define HBCP_CFG_SVH
`define HBCP_WORD_BITS 16
`define HBCP_NUM_SWITCH 8
`define HBCP_FIFO_DEPTH 8
`define HBCP_CMD_RESET 16'he000
`define HBCP_BIT_CLEAR 0
`define HBCP_BIT_SWITCH_LO 1
`define HBCP_BIT_OPEN_LOAD_N 13
`define HBCP_BIT_DELAY_LONG 14
`define HBCP_BIT_SW_ENABLE 15
`define HBCP_STS_PREWARN 0
`define HBCP_STS_SHORT 13
`define HBCP_STS_ENABLE 14
`define HBCP_STS_SUPPLY 15
`define HBCP_CLK_MHZ 250
`define HBCP_DELAY_LONG_US 12000
`define HBCP_DELAY_SHORT_US 1500
`define HBCP_DELAY_LONG_CYC (`HBCP_DELAY_LONG_US * `HBCP_CLK_MHZ)
`define HBCP_DELAY_SHORT_CYC (`HBCP_DELAY_SHORT_US * `HBCP_CLK_MHZ)
`endif

// ===== hw/hbcp_pkg.sv
// Types shared by the half-bridge command port
package hbcp_pkg;
   // Command word layout, most significant field first
   typedef struct packed {
      logic software_enable_bit;
      logic short_trip_delay_choice;
      logic open_load_detect_n;
      logic [3:0] unused;
      logic [7:0] switch_ctl;
      logic clear_fault_flags;
   } hbcp_cmd_type;

   // Synchronised pin inputs, one bit each unless noted
   typedef struct packed {
      logic frame_n;
      logic hw_enable;
      logic thermal_prewarning;
      logic overtemp_shutdown;
      logic supply_undervolt;
      logic [7:0] overcurrent;
      logic [7:0] open_load;
   } hbcp_pins_type;

   // Command apply sequencer
   typedef enum logic [2:0] {
      HBCP_IDLE  = 3'b001,
      HBCP_LOAD  = 3'b010,
      HBCP_CLEAR = 3'b100
   } hbcp_state_type;
endpackage : hbcp_pkg

// ===== hw/hbcp_fifo.sv
// Word FIFO between frame capture and command apply
`timescale 1ns/1ps
module hbcp_fifo #(
   parameter int WIDTH = 16,
   parameter int DEPTH = 8
) (
   input wire logic i_clk,                 // System clock
   input wire logic i_rst_n,               // Synchronised reset, active low
   input wire logic i_wr_valid,            // Write word offered
   output logic o_wr_ready,                // Room for a word
   input wire logic [WIDTH-1:0] i_wr_data, // Write word
   output logic o_rd_valid,                // Word available
   input wire logic i_rd_ready,            // Reader takes word
   output logic [WIDTH-1:0] o_rd_data      // Head word
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_r [DEPTH];
   logic [AW-1:0] wptr_r, wptr_nxt, rptr_r, rptr_nxt;
   logic [AW:0] cnt_r, cnt_nxt;
   logic do_wr, do_rd;

   // Handshake terms from fill level
   assign o_wr_ready = (cnt_r != DEPTH[AW:0]);
   assign o_rd_valid = (cnt_r != '0);
   assign do_wr = i_wr_valid & o_wr_ready;
   assign do_rd = i_rd_ready & o_rd_valid;
   assign o_rd_data = mem_r[rptr_r];

   // Pointer and count update
   always_comb begin
      wptr_nxt = wptr_r;
      rptr_nxt = rptr_r;
      cnt_nxt = cnt_r;
      if (do_wr) begin
         wptr_nxt = (wptr_r == AW'(DEPTH - 1)) ? '0 : wptr_r + 1'b1;
      end
      if (do_rd) begin
         rptr_nxt = (rptr_r == AW'(DEPTH - 1)) ? '0 : rptr_r + 1'b1;
      end
      if (do_wr && !do_rd) begin
         cnt_nxt = cnt_r + 1'b1;
      end else if (do_rd && !do_wr) begin
         cnt_nxt = cnt_r - 1'b1;
      end
   end

   // Pointer registers
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         wptr_r <= '0;
         rptr_r <= '0;
         cnt_r <= '0;
      end else begin
         wptr_r <= wptr_nxt;
         rptr_r <= rptr_nxt;
         cnt_r <= cnt_nxt;
      end
   end

   // Storage, written only on accepted words
   always_ff @(posedge i_clk) begin
      if (do_wr) begin
         mem_r[wptr_r] <= i_wr_data;
      end
   end
endmodule : hbcp_fifo

// ===== hw/hbcp_top.sv
// Serial command port of an octal half-bridge driver
`timescale 1ns/1ps
`include "hbcp_cfg.svh"
module hbcp_top #(
   parameter int unsigned DELAY_LONG_CYC = `HBCP_DELAY_LONG_CYC,
   parameter int unsigned DELAY_SHORT_CYC = `HBCP_DELAY_SHORT_CYC,
   parameter int FIFO_DEPTH = `HBCP_FIFO_DEPTH
) (
   input wire logic i_clk,                    // System clock, 250 MHz
   input wire logic i_arst_n,                 // Async reset, active low
   input wire logic i_link_clk,               // Link clock from host
   input wire logic i_frame_n,                // Frame strobe, active low
   input wire logic i_command_in_line,        // Serial command data
   output logic o_status_out,                 // Serial status data
   output logic o_status_out_oe,              // Status line drive enable
   input wire logic i_hw_enable,              // Hardware enable pin
   input wire logic i_thermal_prewarning,     // Thermal warning level
   input wire logic i_overtemp_shutdown,      // Over-temperature level
   input wire logic i_supply_undervolt,       // Supply undervoltage level
   input wire logic [7:0] i_overcurrent,      // Per-output overcurrent
   input wire logic [7:0] i_open_load,        // Per-output open load
   output logic [7:0] o_switch_on,            // Output stage drive
   output logic o_open_load_enable,           // Open-load current on
   output logic o_short_delay_long,           // Long trip delay chosen
   output logic o_enabled,                    // Combined enable
   output logic o_clear_fault_flags,          // One-cycle clear pulse
   output logic o_short_trip_flag             // Sticky short trip
);
   localparam int W = `HBCP_WORD_BITS;
   localparam int NP = $bits(hbcp_pkg::hbcp_pins_type);
   localparam logic [4:0] FULL_CNT = 5'h10;
   // Pin levels assumed in reset: strobe idle high, enable pin high, faults quiet
   localparam hbcp_pkg::hbcp_pins_type PINS_IDLE = '{frame_n: 1'b1, hw_enable: 1'b1,
                                                      default: '0};

   // Reset release through two flops
   logic [1:0] rst_sync_r;
   logic rst_n;
   always_ff @(posedge i_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         rst_sync_r <= 2'h0;
      end else begin
         rst_sync_r <= {rst_sync_r[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_r[1];

   // ---------------- Link domain ----------------
   // Strobe high re-arms the link logic; the shifted word stays put for capture
   logic [W-1:0] shift_r, shift_nxt;
   logic [4:0] in_cnt_r, in_cnt_nxt;
   logic [4:0] out_idx_r, out_idx_nxt;
   logic started_r, started_nxt;
   logic [W-1:0] snap_r, snap_nxt;
   logic fresh_r;

   // Set while the strobe is high, dropped at the first falling edge of a frame
   always_ff @(negedge i_link_clk or posedge i_frame_n) begin
      if (i_frame_n) begin
         fresh_r <= 1'b1;
      end else begin
         fresh_r <= 1'b0;
      end
   end

   // Falling-edge sampler, LSB arrives first so it ends at bit 0
   always_comb begin
      shift_nxt = {i_command_in_line, shift_r[W-1:1]};
      in_cnt_nxt = (in_cnt_r == FULL_CNT) ? in_cnt_r : in_cnt_r + 5'h01;
      if (fresh_r) begin
         in_cnt_nxt = 5'h01;
      end
   end

   // No strobe reset here: the capture reads these after the strobe rises
   always_ff @(negedge i_link_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         shift_r <= '0;
         in_cnt_r <= 5'h00;
      end else begin
         shift_r <= shift_nxt;
         in_cnt_r <= in_cnt_nxt;
      end
   end

   // Rising-edge status pointer; first edge keeps bit 0 on the line
   always_comb begin
      started_nxt = 1'b1;
      out_idx_nxt = out_idx_r;
      if (started_r && out_idx_r != FULL_CNT) begin
         out_idx_nxt = out_idx_r + 5'h01;
      end
   end

   always_ff @(posedge i_link_clk or posedge i_frame_n) begin
      if (i_frame_n) begin
         started_r <= 1'b0;
         out_idx_r <= 5'h00;
      end else begin
         started_r <= started_nxt;
         out_idx_r <= out_idx_nxt;
      end
   end

   // Status line: snapshot bit by pointer, zero past the word
   always_comb begin
      o_status_out = 1'b0;
      if (out_idx_r < FULL_CNT) begin
         o_status_out = snap_r[out_idx_r[3:0]];
      end
   end
   assign o_status_out_oe = ~i_frame_n;

   // ---------------- Pin synchronisers ----------------
   hbcp_pkg::hbcp_pins_type pins_raw, pins;
   logic [NP-1:0] s1_r, s2_r, s3_r, filt_r, filt_nxt;
   assign pins_raw = '{frame_n: i_frame_n, hw_enable: i_hw_enable,
                       thermal_prewarning: i_thermal_prewarning,
                       overtemp_shutdown: i_overtemp_shutdown,
                       supply_undervolt: i_supply_undervolt,
                       overcurrent: i_overcurrent, open_load: i_open_load};

   // Level changes when second and third stages agree
   for (genvar g = 0; g < NP; g++) begin : g_filt
      assign filt_nxt[g] = (s2_r[g] == s3_r[g]) ? s3_r[g] : filt_r[g];
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_r <= PINS_IDLE;
         s2_r <= PINS_IDLE;
         s3_r <= PINS_IDLE;
         filt_r <= PINS_IDLE;
      end else begin
         s1_r <= pins_raw;
         s2_r <= s1_r;
         s3_r <= s2_r;
         filt_r <= filt_nxt;
      end
   end
   assign pins = filt_r;

   // ---------------- Frame capture ----------------
   logic frame_d_r, frame_end;
   logic cap_valid_r, cap_valid_nxt;
   logic [W-1:0] cap_word_r, cap_word_nxt;
   logic fifo_wr_ready, fifo_rd_valid, fifo_rd_ready;
   logic [W-1:0] fifo_rd_data;
   assign frame_end = pins.frame_n & ~frame_d_r;

   // Link registers are still after the strobe rises, so they are read here
   always_comb begin
      cap_valid_nxt = cap_valid_r;
      cap_word_nxt = cap_word_r;
      if (cap_valid_r && fifo_wr_ready) begin
         cap_valid_nxt = 1'b0;
      end
      if (frame_end && in_cnt_r == FULL_CNT && !cap_valid_nxt) begin
         cap_valid_nxt = 1'b1;
         cap_word_nxt = shift_r;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         frame_d_r <= 1'b1;
         cap_valid_r <= 1'b0;
         cap_word_r <= '0;
      end else begin
         frame_d_r <= pins.frame_n;
         cap_valid_r <= cap_valid_nxt;
         cap_word_r <= cap_word_nxt;
      end
   end

   hbcp_fifo #(
      .WIDTH(W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_clk(i_clk),
      .i_rst_n(rst_n),
      .i_wr_valid(cap_valid_r),
      .o_wr_ready(fifo_wr_ready),
      .i_wr_data(cap_word_r),
      .o_rd_valid(fifo_rd_valid),
      .i_rd_ready(fifo_rd_ready),
      .o_rd_data(fifo_rd_data)
   );

   // ---------------- Command apply ----------------
   hbcp_pkg::hbcp_state_type state_r, state_nxt;
   hbcp_pkg::hbcp_cmd_type cmd_r, cmd_nxt;
   logic [W-1:0] pend_r, pend_nxt;
   logic clear_pulse;
   assign fifo_rd_ready = (state_r == hbcp_pkg::HBCP_IDLE);

   // Take a word, load it, then issue its clear request
   always_comb begin
      state_nxt = state_r;
      cmd_nxt = cmd_r;
      pend_nxt = pend_r;
      clear_pulse = 1'b0;
      unique case (state_r)
         hbcp_pkg::HBCP_IDLE: begin
            if (fifo_rd_valid) begin
               pend_nxt = fifo_rd_data;
               state_nxt = hbcp_pkg::HBCP_LOAD;
            end
         end
         hbcp_pkg::HBCP_LOAD: begin
            cmd_nxt = pend_r;
            state_nxt = hbcp_pkg::HBCP_CLEAR;
         end
         hbcp_pkg::HBCP_CLEAR: begin
            clear_pulse = cmd_r.clear_fault_flags;
            state_nxt = hbcp_pkg::HBCP_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_r <= hbcp_pkg::HBCP_IDLE;
         cmd_r <= `HBCP_CMD_RESET;
         pend_r <= '0;
      end else begin
         state_r <= state_nxt;
         cmd_r <= cmd_nxt;
         pend_r <= pend_nxt;
      end
   end

   // ---------------- Short-trip filters ----------------
   logic [31:0] trip_lim;
   logic [7:0] trip_r, trip_nxt;
   logic [31:0] oc_cnt_r [8];
   logic [31:0] oc_cnt_nxt [8];
   assign trip_lim = cmd_r.short_trip_delay_choice ? DELAY_LONG_CYC : DELAY_SHORT_CYC;

   // Overcurrent must persist for the chosen delay before a trip
   for (genvar o = 0; o < 8; o++) begin : g_trip
      always_comb begin
         oc_cnt_nxt[o] = 32'h0;
         trip_nxt[o] = trip_r[o];
         if (pins.overcurrent[o] && o_switch_on[o]) begin
            oc_cnt_nxt[o] = oc_cnt_r[o] + 32'h1;
            if (oc_cnt_nxt[o] >= trip_lim) begin
               trip_nxt[o] = 1'b1;
            end
         end else if (clear_pulse) begin
            trip_nxt[o] = 1'b0;
         end
      end

      always_ff @(posedge i_clk or negedge rst_n) begin
         if (!rst_n) begin
            oc_cnt_r[o] <= 32'h0;
            trip_r[o] <= 1'b0;
         end else begin
            oc_cnt_r[o] <= oc_cnt_nxt[o];
            trip_r[o] <= trip_nxt[o];
         end
      end
   end

   // ---------------- Fault flags ----------------
   logic supply_fail_r, supply_fail_nxt;
   logic short_flag_r, short_flag_nxt;
   logic overtemp_r, overtemp_nxt;

   // Sticky flags; a new event in the clear cycle keeps the flag set
   always_comb begin
      supply_fail_nxt = pins.supply_undervolt | (supply_fail_r & ~clear_pulse);
      short_flag_nxt = (|(trip_nxt & ~trip_r)) | (short_flag_r & ~clear_pulse);
      overtemp_nxt = pins.overtemp_shutdown | (overtemp_r & ~clear_pulse);
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         supply_fail_r <= 1'b0;
         short_flag_r <= 1'b0;
         overtemp_r <= 1'b0;
      end else begin
         supply_fail_r <= supply_fail_nxt;
         short_flag_r <= short_flag_nxt;
         overtemp_r <= overtemp_nxt;
      end
   end

   // ---------------- Outputs ----------------
   logic enabled;
   logic [7:0] sw_nxt;
   logic [7:0] sw_r;
   logic clr_out_r;
   assign enabled = cmd_r.software_enable_bit & pins.hw_enable;

   // Stage drive gated by enable, trips and thermal shutdown
   always_comb begin
      sw_nxt = 8'h00;
      if (enabled && !overtemp_r) begin
         sw_nxt = cmd_r.switch_ctl & ~trip_r;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         sw_r <= 8'h00;
         clr_out_r <= 1'b0;
      end else begin
         sw_r <= sw_nxt;
         clr_out_r <= clear_pulse;
      end
   end
   assign o_switch_on = sw_r;
   assign o_clear_fault_flags = clr_out_r;
   assign o_open_load_enable = ~cmd_r.open_load_detect_n;
   assign o_short_delay_long = cmd_r.short_trip_delay_choice;
   assign o_enabled = enabled;
   assign o_short_trip_flag = short_flag_r;

   // ---------------- Status snapshot ----------------
   logic [W-1:0] live;

   // Live status word; thermal shutdown forces every bit high
   always_comb begin
      live = '0;
      live[`HBCP_STS_PREWARN] = pins.thermal_prewarning;
      live[`HBCP_BIT_SWITCH_LO +: 8] = o_open_load_enable ? pins.open_load : sw_r;
      live[`HBCP_STS_SHORT] = short_flag_r;
      live[`HBCP_STS_ENABLE] = enabled;
      live[`HBCP_STS_SUPPLY] = supply_fail_r;
      if (overtemp_r) begin
         live = '1;
      end
   end

   // Snapshot frozen while a frame runs, so link reads a still word
   always_comb begin
      snap_nxt = pins.frame_n ? live : snap_r;
   end

   always_ff @(posedge i_clk or negedge rst_n) begin
      if (!rst_n) begin
         snap_r <= '0;
      end else begin
         snap_r <= snap_nxt;
      end
   end
endmodule : hbcp_top

// ===== tb/hbcp_properties.sv
// Concurrent checks on the command port pins
`timescale 1ns/1ps
module hbcp_properties (
   input wire logic i_clk,               // System clock
   input wire logic i_arst_n,            // Async reset, active low
   input wire logic i_frame_n,           // Frame strobe
   input wire logic i_hw_enable,         // Hardware enable pin
   input wire logic [7:0] i_overcurrent, // Per-output overcurrent
   input wire logic o_status_out_oe,     // Status drive enable
   input wire logic [7:0] o_switch_on,   // Output stage drive
   input wire logic o_open_load_enable,  // Open-load current on
   input wire logic o_short_delay_long,  // Long trip delay chosen
   input wire logic o_enabled,           // Combined enable
   input wire logic o_clear_fault_flags, // Clear pulse
   input wire logic o_short_trip_flag    // Sticky short trip
);
   // Any output reporting overcurrent
   wire logic oc_any = |i_overcurrent;
   default clocking @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);
   a_oe_tracks_frame: assert property (
      o_status_out_oe == !i_frame_n) else $error("status drive not tied to frame");
   a_apply_frame_end: assert property (
      !i_frame_n [*8] |-> $stable(o_open_load_enable) && $stable(o_short_delay_long)
      && $stable(o_switch_on)) else $error("settings changed inside a frame");
   a_hw_off_disables: assert property (
      !i_hw_enable [*8] |-> !o_enabled) else $error("enabled with pin low");
   a_off_means_idle: assert property (
      !o_enabled [*2] |-> o_switch_on == 8'h00) else $error("outputs on while disabled");
   a_clear_one_cycle: assert property (
      o_clear_fault_flags |=> !o_clear_fault_flags) else $error("clear pulse too long");
   a_clear_drops_trip: assert property (
      o_clear_fault_flags && i_overcurrent == 8'h00 |-> !o_short_trip_flag)
      else $error("short flag kept after clear");
   a_trip_only_clear: assert property (
      $fell(o_short_trip_flag) |-> o_clear_fault_flags) else $error("short flag lost");
   a_trip_needs_fault: assert property (
      $rose(o_short_trip_flag) |-> $past(oc_any, 6)) else $error("short flag without fault");
endmodule : hbcp_properties

bind hbcp_top hbcp_properties u_hbcp_properties (
   .i_clk(i_clk), .i_arst_n(i_arst_n), .i_frame_n(i_frame_n), .i_hw_enable(i_hw_enable),
   .i_overcurrent(i_overcurrent), .o_status_out_oe(o_status_out_oe),
   .o_switch_on(o_switch_on), .o_open_load_enable(o_open_load_enable),
   .o_short_delay_long(o_short_delay_long), .o_enabled(o_enabled),
   .o_clear_fault_flags(o_clear_fault_flags), .o_short_trip_flag(o_short_trip_flag)
);

// ===== tb/hbcp_host_model.sv
// Host side of the serial link: strobe, link clock and command line
`timescale 1ns/1ps
module hbcp_host_model (
   output logic o_link_clk,     // Link clock, low between frames
   output logic o_frame_n,      // Frame strobe
   output logic o_data,         // Command bit
   input wire logic i_status,   // Status bit
   input wire logic i_status_oe // Status drive enable
);
   // Idle link: strobe high, clock still, data at its pull-down level
   initial begin
      o_link_clk = 1'b0;
      o_frame_n = 1'b1;
      o_data = 1'b0;
   end
   // One frame of n bits, LSB first; status taken at each of the first 16 falling edges
   task automatic xfer(input logic [31:0] w, input int n, output logic [15:0] sts);
      sts = 16'h0000;
      o_frame_n = 1'b0;
      #40;
      for (int i = 0; i < n; i++) begin
         #1 o_data = w[i];
         #2 o_link_clk = 1'b1;
         #3 if (i < 16) sts[i] = i_status_oe ? i_status : 1'bx;
         o_link_clk = 1'b0;
      end
      #4 o_frame_n = 1'b1;
      o_data = 1'b0;
      #120;
   endtask : xfer
endmodule : hbcp_host_model

// ===== tb/hbcp_top_tb.sv
// Self-checking bench for the half-bridge command port
`timescale 1ns/1ps
module hbcp_top_tb;
   logic i_clk = 1'b0;
   logic i_arst_n = 1'b0;
   logic hw_en = 1'b1;
   logic uv = 1'b0;
   logic ot = 1'b0;
   logic tp = 1'b1;
   logic [7:0] oc = 8'h00;
   logic link_clk, frame_n, din, sdo, sdo_oe, ole, dl, en, clr, trip;
   logic [7:0] sw;
   logic [15:0] sts, prev;
   int fails = 0, num_checks = 0, cyc = 0, clr_cnt = 0, c0;
   // Rows: command word, then expected {switches, open-load on, long delay, enabled}
   logic [31:0] rows [4] = '{32'h81fe_07fd, 32'he0aa_02ab, 32'h5e54_0006, 32'h8154_0555};

   hbcp_top #(.DELAY_LONG_CYC(40), .DELAY_SHORT_CYC(10)) u_hbcp_top (
      .i_clk(i_clk), .i_arst_n(i_arst_n), .i_link_clk(link_clk), .i_frame_n(frame_n),
      .i_command_in_line(din), .o_status_out(sdo), .o_status_out_oe(sdo_oe),
      .i_hw_enable(hw_en), .i_thermal_prewarning(tp), .i_overtemp_shutdown(ot),
      .i_supply_undervolt(uv), .i_overcurrent(oc), .i_open_load(8'h3c),
      .o_switch_on(sw), .o_open_load_enable(ole), .o_short_delay_long(dl),
      .o_enabled(en), .o_clear_fault_flags(clr), .o_short_trip_flag(trip));
   hbcp_host_model u_hbcp_host_model (
      .o_link_clk(link_clk), .o_frame_n(frame_n), .o_data(din),
      .i_status(sdo), .i_status_oe(sdo_oe));

   // System clock
   always #2 i_clk = ~i_clk;
   // Clear pulse counter and hang guard
   always @(posedge i_clk) begin
      cyc++;
      if (clr === 1'b1) clr_cnt++;
      if (cyc == 5000) begin
         fails++;
         final_report();
      end
   end

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   task automatic final_report;
      $display("checks=%0d fails=%0d", num_checks, fails);
      if (fails == 0 && num_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : final_report
   // Expected status from the settings in force: prewarn high, open loads 3c
   function automatic logic [15:0] st_of(input logic [15:0] p);
      return {1'b0, p[0], 1'b0, 4'h0, p[2] ? 8'h3c : p[10:3], 1'b1};
   endfunction : st_of
   function automatic logic [15:0] outs();
      return {5'h00, sw, ole, dl, en};
   endfunction : outs

   // Main sequence
   initial begin
      repeat (2) @(posedge i_clk);
      #1 i_arst_n = 1'b1;
      repeat (8) @(posedge i_clk);
      #1 prev = 16'h0003;
      chk(outs(), prev);
      for (int r = 0; r < 4; r++) begin
         u_hbcp_host_model.xfer({16'h0000, rows[r][31:16]}, 16, sts);
         chk(sts, st_of(prev));
         chk(outs(), rows[r][15:0]);
         prev = rows[r][15:0];
      end
      // Frame cut short is dropped, an over-long one keeps its last 16 bits
      u_hbcp_host_model.xfer(32'h0000_0000, 12, sts);
      chk(outs(), prev);
      u_hbcp_host_model.xfer({12'h000, 16'h81fe, 4'h5}, 20, sts);
      chk(outs(), 16'h07fd);
      // Overcurrent on the first output trips it; undervoltage latches
      @(posedge i_clk) #1 oc = 8'h01;
      uv = 1'b1;
      repeat (30) @(posedge i_clk);
      #1 oc = 8'h00;
      uv = 1'b0;
      repeat (6) @(posedge i_clk);
      chk({15'h0000, trip}, 16'h0001);
      chk({8'h00, sw}, 16'h00fe);
      u_hbcp_host_model.xfer(32'h81fe, 16, sts);
      chk(sts, 16'he079);
      // Thermal shutdown latches: outputs off, status all ones until cleared
      @(posedge i_clk) #1 ot = 1'b1;
      repeat (10) @(posedge i_clk);
      #1 ot = 1'b0;
      repeat (6) @(posedge i_clk);
      #1 chk({8'h00, sw}, 16'h0000);
      u_hbcp_host_model.xfer(32'h81fe, 16, sts);
      chk(sts, 16'hffff);
      // Clear request drops the sticky flags and re-arms the output
      c0 = clr_cnt;
      u_hbcp_host_model.xfer(32'h81ff, 16, sts);
      chk({15'h0000, trip}, 16'h0000);
      chk(clr_cnt[15:0], c0[15:0] + 16'h0001);
      chk({8'h00, sw}, 16'h00ff);
      u_hbcp_host_model.xfer(32'h81fe, 16, sts);
      chk(sts, 16'h4079);
      // Pin disable: outputs off, port keeps answering
      @(posedge i_clk) #1 hw_en = 1'b0;
      repeat (10) @(posedge i_clk);
      chk(outs(), 16'h0004);
      u_hbcp_host_model.xfer(32'h81fe, 16, sts);
      chk(sts, 16'h0079);
      // Reset in mid-run restores the command word; the port answers again
      @(posedge i_clk) #1 i_arst_n = 1'b0;
      tp = 1'b0;
      repeat (2) @(posedge i_clk);
      #1 i_arst_n = 1'b1;
      repeat (8) @(posedge i_clk);
      #1 chk(outs(), 16'h0002);
      u_hbcp_host_model.xfer(32'h81fe, 16, sts);
      chk(sts, 16'h0000);
      chk(outs(), 16'h0004);
      final_report();
   end
endmodule : hbcp_top_tb
